//--- hw/pmf_chain.sv
// Operation
// - Active power is voltage times current, averaged by two low-pass stages.
// - Reactive power uses the same path with voltage shifted 90 degrees.
// - Hilbert span is 2M+1 taps; weighted taps inside kept, outside dropped.
// - Ideal taps (2/pi)sin^2(pi n/2)/n; centre and even offsets are zero.
// - Window weights are Kaiser shaped; beta zero means all ones.
// - Phase shifter is causal, delayed by M samples.
// - Odd length; input also delayed M samples to align with shifted output.
// - Rogowski current path: high-pass, integrator, then second high-pass.
// - Second high-pass removes DC left at integrator output.
// - Integrator accumulates, giving -20 dB/decade and 90 degree lag.
// - Voltage may pass the same high-pass filters to match phase.
// - Shunt mode uses one high-pass in each path, no integrator.
// - Each first-order stage computes b1 x(n) + b2 x(n-1) - a2 y(n-1).
`timescale 1ns/10ps
`default_nettype none

module pmf_chain
  import pmf_pkg::*;
#(
  parameter int W  = SMP_W,
  parameter int CW = COEF_W,
  parameter int HM = HILB_M_MAX,
  parameter int NT = 2 * HM + 1,
  parameter int MW = $clog2(HM + 1)
) (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 cfg_ld_i,
  input  wire logic                 cfg_rogo_i,
  input  wire logic                 cfg_vcomp_i,
  input  wire logic [MW-1:0]        cfg_hilb_m_i,
  input  wire logic [CW-1:0]        cfg_hp_b1_i,
  input  wire logic [CW-1:0]        cfg_hp_b2_i,
  input  wire logic [CW-1:0]        cfg_hp_a2_i,
  input  wire logic [CW-1:0]        cfg_lp_b1_i,
  input  wire logic [CW-1:0]        cfg_lp_b2_i,
  input  wire logic [CW-1:0]        cfg_lp_a2_i,
  input  wire logic [NT*CW-1:0]     cfg_hilb_coef_i,
  input  wire logic                 smp_stb_i,
  input  wire logic signed [W-1:0]  volt_i,
  input  wire logic signed [W-1:0]  curr_i,
  output logic signed [W-1:0]       act_pwr_o,
  output logic signed [W-1:0]       react_pwr_o,
  output logic                      pwr_vld_o
);

  typedef struct packed {
    pmf_mode_t                mode;
    logic                     vcomp;
    logic [MW-1:0]            hm;
    logic [CW-1:0]            hb1;
    logic [CW-1:0]            hb2;
    logic [CW-1:0]            ha2;
    logic [CW-1:0]            lb1;
    logic [CW-1:0]            lb2;
    logic [CW-1:0]            la2;
    logic [NT-1:0][CW-1:0]    hc;
    logic [NT-2:0][W-1:0]     vdel;
    logic [NT-2:0][W-1:0]     idel;
    logic [W-1:0]             act;
    logic [W-1:0]             react;
    logic                     vld;
  } pmf_state_t;

  pmf_state_t st_r;
  pmf_state_t st_nxt;

  logic rogo;
  logic signed [W-1:0] i_hp1, i_int, i_hp2, i_cond;
  logic signed [W-1:0] v_hp1, v_hp2, v_cond;
  logic signed [W-1:0] hx [NT];
  logic signed [W-1:0] ix [NT];
  logic signed [W-1:0] v_del, i_del, v_90;
  logic signed [ACC_W-1:0] hacc;
  logic signed [W-1:0] pw_in [2];
  logic signed [W-1:0] pw_s1 [2];
  logic signed [W-1:0] pw_s2 [2];

  assign rogo = (st_r.mode == PMF_MODE_ROGO);

  // Current conditioning
  pmf_iir1 u_i_hp1 (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .en_i     (smp_stb_i),
    .x_i      (curr_i),
    .b1_i     (st_r.hb1),
    .b2_i     (st_r.hb2),
    .a2_i     (st_r.ha2),
    .y_o      (i_hp1)
  );

  // Integrator is a stage with fixed coefficients; the first high-pass
  // keeps its input free of DC so it cannot run into saturation
  pmf_iir1 u_i_int (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .en_i     (smp_stb_i && rogo),
    .x_i      (i_hp1),
    .b1_i     (COEF_ONE),
    .b2_i     (COEF_ZERO),
    .a2_i     (COEF_NEG_ONE),
    .y_o      (i_int)
  );

  pmf_iir1 u_i_hp2 (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .en_i     (smp_stb_i && rogo),
    .x_i      (i_int),
    .b1_i     (st_r.hb1),
    .b2_i     (st_r.hb2),
    .a2_i     (st_r.ha2),
    .y_o      (i_hp2)
  );

  assign i_cond = rogo ? i_hp2 : i_hp1;

  // Voltage conditioning, optionally matched to the current path
  pmf_iir1 u_v_hp1 (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .en_i     (smp_stb_i),
    .x_i      (volt_i),
    .b1_i     (st_r.hb1),
    .b2_i     (st_r.hb2),
    .a2_i     (st_r.ha2),
    .y_o      (v_hp1)
  );

  pmf_iir1 u_v_hp2 (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .en_i     (smp_stb_i && rogo && st_r.vcomp),
    .x_i      (v_hp1),
    .b1_i     (st_r.hb1),
    .b2_i     (st_r.hb2),
    .a2_i     (st_r.ha2),
    .y_o      (v_hp2)
  );

  assign v_cond = (rogo && st_r.vcomp) ? v_hp2 : v_hp1;

  // Tap k holds the sample k strobes old
  assign hx[0] = v_cond;
  assign ix[0] = i_cond;
  for (genvar k = 1; k < NT; k++) begin : g_tap
    assign hx[k] = $signed(st_r.vdel[k-1]);
    assign ix[k] = $signed(st_r.idel[k-1]);
  end

  // Delayed samples line up with the filter centre
  assign v_del = hx[st_r.hm];
  assign i_del = ix[st_r.hm];

  // Loaded taps carry ideal value times window weight; span and parity
  // are enforced here so a bad load cannot leak even taps
  always_comb begin
    hacc = '0;
    for (int k = 0; k < NT; k++) begin
      if (pmf_tap_live(k, int'(st_r.hm))) begin
        hacc = hacc + ACC_W'($signed(st_r.hc[k]) * hx[k]);
      end
    end
  end
  assign v_90 = pmf_sat(hacc >>> COEF_FRAC);

  assign pw_in[0] = pmf_sat(ACC_W'(v_del * i_del) >>> (W - 1));
  assign pw_in[1] = pmf_sat(ACC_W'(v_90 * i_del) >>> (W - 1));

  for (genvar g = 0; g < 2; g++) begin : g_pwr
    pmf_iir1 u_lp1 (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .en_i     (smp_stb_i),
      .x_i      (pw_in[g]),
      .b1_i     (st_r.lb1),
      .b2_i     (st_r.lb2),
      .a2_i     (st_r.la2),
      .y_o      (pw_s1[g])
    );

    pmf_iir1 u_lp2 (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .en_i     (smp_stb_i),
      .x_i      (pw_s1[g]),
      .b1_i     (st_r.lb1),
      .b2_i     (st_r.lb2),
      .a2_i     (st_r.la2),
      .y_o      (pw_s2[g])
    );
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.vld = 1'b0;
    // A load coinciding with a strobe is dropped to keep the sample clean
    if (cfg_ld_i && !smp_stb_i) begin
      st_nxt.mode  = cfg_rogo_i ? PMF_MODE_ROGO : PMF_MODE_SHUNT;
      st_nxt.vcomp = cfg_vcomp_i;
      st_nxt.hm    = (int'(cfg_hilb_m_i) > HM) ? MW'(HM) : cfg_hilb_m_i;
      st_nxt.hb1   = cfg_hp_b1_i;
      st_nxt.hb2   = cfg_hp_b2_i;
      st_nxt.ha2   = cfg_hp_a2_i;
      st_nxt.lb1   = cfg_lp_b1_i;
      st_nxt.lb2   = cfg_lp_b2_i;
      st_nxt.la2   = cfg_lp_a2_i;
      st_nxt.hc    = cfg_hilb_coef_i;
    end
    if (smp_stb_i) begin
      st_nxt.vdel  = {st_r.vdel[NT-3:0], v_cond};
      st_nxt.idel  = {st_r.idel[NT-3:0], i_cond};
      st_nxt.act   = pw_s2[0];
      st_nxt.react = pw_s2[1];
      st_nxt.vld   = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r    <= '0;
      st_r.hm <= MW'(HILB_M_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign act_pwr_o   = st_r.act;
  assign react_pwr_o = st_r.react;
  assign pwr_vld_o   = st_r.vld;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_load_quiet;
    cfg_ld_i && !smp_stb_i;
  endsequence

  sequence s_strobe_pair;
    smp_stb_i ##1 smp_stb_i;
  endsequence

  chk_vld_per_strobe: assert property (smp_stb_i |=> pwr_vld_o)
    else $error("no valid after strobe");
  chk_out_hold: assert property (
    !smp_stb_i |=> $stable(act_pwr_o) && $stable(react_pwr_o) && !pwr_vld_o)
    else $error("output moved without strobe");
  chk_act_from_lpf: assert property (
    smp_stb_i |=> act_pwr_o == $past(pw_s2[0]))
    else $error("active power not from second low-pass");
  chk_react_from_lpf: assert property (
    smp_stb_i |=> react_pwr_o == $past(pw_s2[1]))
    else $error("reactive power not from second low-pass");
  chk_delay_line: assert property (
    s_strobe_pair |=> st_r.vdel[1] == $past(v_cond, 2))
    else $error("voltage delay line misaligned");
  chk_shunt_path: assert property (!rogo |-> i_cond == i_hp1)
    else $error("shunt current path not single high-pass");
  chk_rogo_path: assert property (rogo |-> i_cond == i_hp2)
    else $error("rogowski current path not after second high-pass");
  chk_vcomp_path: assert property (
    rogo && st_r.vcomp |-> v_cond == v_hp2)
    else $error("voltage not matched to current path");
  chk_cfg_load: assert property (
    s_load_quiet |=> st_r.hb1 == $past(cfg_hp_b1_i))
    else $error("configuration not taken");
  chk_cfg_hold: assert property (
    !cfg_ld_i |=> $stable(st_r.hc) && $stable(st_r.mode))
    else $error("configuration moved without load");
  // Outer taps sit at an odd offset when m is odd, so test offset two
  chk_span_even: assert property (
    !pmf_tap_live(int'(st_r.hm), int'(st_r.hm))
    && !pmf_tap_live(int'(st_r.hm) + 2, int'(st_r.hm)))
    else $error("centre or even tap live");
  chk_span_edge: assert property (
    !pmf_tap_live(2 * int'(st_r.hm) + 1, int'(st_r.hm)))
    else $error("tap outside span live");

endmodule : pmf_chain

`default_nettype wire

//--- hw/pmf_pkg.sv
package pmf_pkg;

  // Sample and coefficient formats: samples Q1.23, coefficients Q2.22
  localparam int SMP_W     = 24;
  localparam int COEF_W    = 24;
  localparam int COEF_FRAC = 22;
  localparam int ACC_W     = 64;

  // Largest Hilbert half-length; full span is 2M+1 taps
  localparam int HILB_M_MAX = 11;

  // Values after reset
  localparam int                 HILB_M_RST = HILB_M_MAX;
  localparam logic [COEF_W-1:0]  COEF_RST   = 24'h00_0000;
  localparam logic [SMP_W-1:0]   SMP_RST    = 24'h00_0000;

  // Fixed integrator coefficients: y(n) = x(n) + y(n-1)
  localparam logic [COEF_W-1:0]  COEF_ONE     = 24'h40_0000;
  localparam logic [COEF_W-1:0]  COEF_ZERO    = 24'h00_0000;
  localparam logic [COEF_W-1:0]  COEF_NEG_ONE = 24'hC0_0000;

  typedef enum logic {
    PMF_MODE_SHUNT,
    PMF_MODE_ROGO
  } pmf_mode_t;

  // Clamp a wide signed value into one sample word
  function automatic logic signed [SMP_W-1:0] pmf_sat(
    input logic signed [ACC_W-1:0] v
  );
    logic signed [ACC_W-1:0] hi;
    logic signed [ACC_W-1:0] lo;
    hi = ACC_W'((64'sd1 <<< (SMP_W - 1)) - 64'sd1);
    lo = -ACC_W'(64'sd1 <<< (SMP_W - 1));
    if (v > hi) begin
      pmf_sat = hi[SMP_W-1:0];
    end else if (v < lo) begin
      pmf_sat = lo[SMP_W-1:0];
    end else begin
      pmf_sat = v[SMP_W-1:0];
    end
  endfunction : pmf_sat

  // Hilbert tap k is live inside the span and only at odd offsets
  function automatic logic pmf_tap_live(input int k, input int m);
    pmf_tap_live = (k <= 2 * m) && (((k - m) % 2) != 0);
  endfunction : pmf_tap_live

endpackage : pmf_pkg

//--- hw/pmf_iir1.sv
`timescale 1ns/10ps
`default_nettype none

module pmf_iir1
  import pmf_pkg::*;
#(
  parameter int W  = SMP_W,
  parameter int CW = COEF_W,
  parameter int CF = COEF_FRAC
) (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 en_i,
  input  wire logic signed [W-1:0]  x_i,
  input  wire logic signed [CW-1:0] b1_i,
  input  wire logic signed [CW-1:0] b2_i,
  input  wire logic signed [CW-1:0] a2_i,
  output logic signed [W-1:0]       y_o
);

  typedef struct packed {
    logic [W-1:0] xp;
    logic [W-1:0] yp;
  } pmf_iir_state_t;

  pmf_iir_state_t st_r;
  pmf_iir_state_t st_nxt;
  logic signed [ACC_W-1:0] acc;

  always_comb begin
    acc = ACC_W'(b1_i * x_i)
        + ACC_W'(b2_i * $signed(st_r.xp))
        - ACC_W'(a2_i * $signed(st_r.yp));
    y_o = pmf_sat(acc >>> CF);
    st_nxt = st_r;
    if (en_i) begin
      st_nxt.xp = x_i;
      st_nxt.yp = y_o;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_stage_advance: assert property (en_i |=> st_r.yp == $past(y_o))
    else $error("stage state did not take its output");
  chk_stage_hold: assert property (!en_i |=> $stable(st_r))
    else $error("stage state moved without strobe");

endmodule : pmf_iir1

`default_nettype wire

//--- testbench/pmf_afe_model.sv
`timescale 1ns/10ps
`default_nettype none

module pmf_afe_model
  import pmf_pkg::*;
(
  input  wire logic               clk_i,
  output logic                    stb_o,
  output logic signed [SMP_W-1:0] volt_o,
  output logic signed [SMP_W-1:0] curr_o
);
  initial begin
    stb_o  = 1'b0;
    volt_o = SMP_RST;
    curr_o = SMP_RST;
  end

  // Stale data is inverted so a late sample cannot pass by luck
  task automatic put(input logic [SMP_W-1:0] v, input logic [SMP_W-1:0] i);
    stb_o  = 1'b1;
    volt_o = v;
    curr_o = i;
    @(negedge clk_i);
    stb_o  = 1'b0;
    volt_o = ~v;
    curr_o = ~i;
  endtask : put

  // Strobe stays high so the next put follows in the very next cycle
  task automatic put_keep(input logic [SMP_W-1:0] v,
                          input logic [SMP_W-1:0] i);
    stb_o  = 1'b1;
    volt_o = v;
    curr_o = i;
    @(negedge clk_i);
  endtask : put_keep
endmodule : pmf_afe_model
`default_nettype wire

//--- testbench/tb_power_meter_filter_chain.sv
`timescale 1ns/10ps
`default_nettype none

module tb_power_meter_filter_chain;
  import pmf_pkg::*;
  localparam int          HN    = 2 * HILB_M_MAX + 1;
  localparam logic [23:0] HALF  = 24'h20_0000;
  localparam logic [23:0] NHALF = 24'hE0_0000;
  localparam logic [23:0] V5    = 24'h40_0000;
  localparam logic [23:0] Z     = 24'h00_0000;
  logic                    clk_i, arst_n_i, cfg_ld_i, cfg_rogo_i;
  logic [3:0]              cfg_hilb_m_i;
  logic [23:0]             hp_b1, hp_b2, hp_a2, lp_b1, lp_b2, lp_a2;
  logic [HN*COEF_W-1:0]    hc;
  logic                    stb, vld;
  logic signed [SMP_W-1:0] volt, curr, act, react;
  int                      mismatches, compares;

  pmf_chain u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_ld_i(cfg_ld_i),
    .cfg_rogo_i(cfg_rogo_i), .cfg_vcomp_i(cfg_rogo_i),
    .cfg_hilb_m_i(cfg_hilb_m_i), .cfg_hp_b1_i(hp_b1), .cfg_hp_b2_i(hp_b2),
    .cfg_hp_a2_i(hp_a2), .cfg_lp_b1_i(lp_b1), .cfg_lp_b2_i(lp_b2),
    .cfg_lp_a2_i(lp_a2), .cfg_hilb_coef_i(hc), .smp_stb_i(stb),
    .volt_i(volt), .curr_i(curr), .act_pwr_o(act), .react_pwr_o(react),
    .pwr_vld_o(vld));

  pmf_afe_model u_afe (.clk_i(clk_i), .stb_o(stb), .volt_o(volt),
    .curr_o(curr));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic cfg(input logic r, input logic [3:0] m,
                     input logic [23:0] b1, input logic [23:0] a2);
    arst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    chk(act, Z);
    chk(react, Z);
    cfg_rogo_i = r;
    cfg_hilb_m_i = m;
    lp_b1 = b1;
    lp_a2 = a2;
    cfg_ld_i = 1'b1;
    @(negedge clk_i);
    cfg_ld_i = 1'b0;
  endtask : cfg

  // One strobe, answer one cycle later, then held
  task automatic smp(input logic [23:0] v, input logic [23:0] i,
                     input logic [23:0] p, input logic [23:0] q);
    u_afe.put(v, i);
    cfg_ld_i = 1'b0;
    chk({23'h0, vld}, 24'h1);
    chk(act, p);
    chk(react, q);
    @(negedge clk_i);
    chk({23'h0, vld}, 24'h0);
    chk(act, p);
  endtask : smp

  task automatic t_mult();
    cfg(1'b0, 4'h0, COEF_ONE, Z);
    smp(V5, V5, 24'h20_0000, Z);
    smp(V5, 24'hC0_0000, 24'hE0_0000, Z);
    smp(24'h80_0000, 24'h80_0000, 24'h7F_FFFF, Z);
  endtask : t_mult

  task automatic t_hilb();
    hc[23:0] = COEF_ONE;
    hc[47:24] = COEF_ONE;
    hc[71:48] = COEF_NEG_ONE;
    hc[95:72] = COEF_ONE;
    cfg(1'b0, 4'h1, COEF_ONE, Z);
    smp(24'h10_0000, V5, Z, Z);
    smp(24'h20_0000, V5, 24'h08_0000, 24'h10_0000);
    smp(24'h08_0000, V5, 24'h10_0000, 24'hFC_0000);
    smp(Z, V5, 24'h04_0000, 24'hF0_0000);
  endtask : t_hilb

  task automatic t_lowpass();
    cfg(1'b0, 4'h0, HALF, NHALF);
    smp(V5, V5, 24'h08_0000, Z);
    smp(V5, V5, 24'h10_0000, Z);
    smp(V5, V5, 24'h16_0000, Z);
  endtask : t_lowpass

  task automatic t_rogo();
    cfg(1'b1, 4'h0, COEF_ONE, Z);
    smp(V5, 24'h08_0000, 24'h04_0000, Z);
    smp(V5, 24'h08_0000, 24'h08_0000, Z);
    smp(V5, 24'h08_0000, 24'h0C_0000, Z);
  endtask : t_rogo

  // Load raised with the strobe must be dropped
  task automatic t_refuse();
    cfg(1'b0, 4'h0, COEF_ONE, Z);
    lp_b1 = Z;
    @(negedge clk_i);
    cfg_ld_i = 1'b1;
    smp(V5, V5, 24'h20_0000, Z);
    smp(V5, V5, 24'h20_0000, Z);
  endtask : t_refuse

  // Back-to-back strobes; taps as loaded by t_hilb
  task automatic t_burst();
    cfg(1'b0, 4'h1, COEF_ONE, Z);
    u_afe.put_keep(24'h10_0000, V5);
    chk({23'h0, vld}, 24'h1);
    chk(act, Z);
    chk(react, Z);
    u_afe.put(24'h20_0000, V5);
    chk({23'h0, vld}, 24'h1);
    chk(act, 24'h08_0000);
    chk(react, 24'h10_0000);
  endtask : t_burst

  // DC input through real high-pass stages, shunt then Rogowski
  task automatic t_hpass();
    hp_b1 = HALF;
    hp_b2 = NHALF;
    hp_a2 = NHALF;
    cfg(1'b0, 4'h0, COEF_ONE, Z);
    smp(V5, V5, 24'h08_0000, Z);
    smp(V5, V5, 24'h02_0000, Z);
    smp(V5, V5, 24'h00_8000, Z);
    cfg(1'b1, 4'h0, COEF_ONE, Z);
    smp(V5, V5, 24'h02_0000, Z);
    smp(V5, V5, Z, Z);
    smp(V5, V5, 24'hFF_A000, Z);
  endtask : t_hpass

  initial begin
    repeat (2000) @(posedge clk_i);
    mismatches++;
    report_and_stop();
  end

  initial begin
    mismatches = 0;
    compares = 0;
    arst_n_i = 1'b0;
    cfg_ld_i = 1'b0;
    cfg_rogo_i = 1'b0;
    cfg_hilb_m_i = 4'h0;
    hp_b1 = COEF_ONE;
    hp_b2 = Z;
    hp_a2 = Z;
    lp_b1 = Z;
    lp_b2 = Z;
    lp_a2 = Z;
    hc = '0;
    @(negedge clk_i);
    t_mult();
    t_hilb();
    t_lowpass();
    t_rogo();
    t_refuse();
    t_burst();
    t_hpass();
    report_and_stop();
  end
endmodule : tb_power_meter_filter_chain
`default_nettype wire
